/* design/tdp_regs.svh */
// Reset values and default sizes for the two-port memory
`ifndef TDP_REGS_SVH
`define TDP_REGS_SVH

// Default geometry, plain choices where nothing fixes them
`define TDP_DEF_DATA_W 8
`define TDP_DEF_ADDR_W 8
`define TDP_DEF_MASK_W 1

// Reset values of the input and output registers
`define TDP_ADDR_RST_BIT 1'b0
`define TDP_DATA_RST_BIT 1'b0
`define TDP_EN_RST 1'b0
`define TDP_MASK_RST_BIT 1'b1
`define TDP_Q_RST_BIT 1'b0

// Fill value of every word at power up
`define TDP_INIT_BIT 1'b0

// Field position of the single strobe bit in the pipeline tracker
`define TDP_PIPE_LSB 0

`endif

/* design/tdp_pkg.sv */
// Types shared by the two-port memory files
package tdp_pkg;

  // Which ports the memory offers
  typedef enum {
    ONE_PORT_CONFIG,
    SIMPLE_TWO_PORT_CONFIG,
    TRUE_TWO_PORT_CONFIG,
    READ_ONLY_CONFIG
  } tdp_mode_t;

  // How registered ports are clocked
  typedef enum {
    SINGLE_CLOCK,
    WRITE_READ_CLOCK,
    INPUT_OUTPUT_CLOCK,
    INDEPENDENT_CLOCK
  } tdp_clk_scheme_t;

endpackage

/* design/tdp_addr_reg.sv */
// Address capture register with hold
`timescale 1ns/1ps

`include "tdp_regs.svh"

module tdp_addr_reg
  import tdp_pkg::*;
#(
  parameter int ADDR_W = `TDP_DEF_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic hold,
  output logic [ADDR_W-1:0] addr_q
);

  // Hold freezes the captured value, not the pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_q <= {ADDR_W{`TDP_ADDR_RST_BIT}};
    end else if (!hold) begin
      addr_q <= addr_in;
    end
  end

endmodule

/* design/tdp_mem.sv */
// Storage array with two ports, bit mask and registered read data
`timescale 1ns/1ps

`include "tdp_regs.svh"

module tdp_mem
  import tdp_pkg::*;
#(
  parameter int DATA_W = `TDP_DEF_DATA_W,
  parameter int ADDR_W = `TDP_DEF_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic we_a,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [DATA_W-1:0] wdata_a,
  input wire logic [DATA_W-1:0] bits_a,
  input wire logic re_a,
  input wire logic we_b,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [DATA_W-1:0] wdata_b,
  input wire logic re_b,
  output logic [DATA_W-1:0] rdata_a,
  output logic [DATA_W-1:0] rdata_b
);

  localparam int DEPTH = 1 << ADDR_W;

  // Power-up fill here; only the write process may drive the array
  logic [DATA_W-1:0] store [DEPTH] = '{default: {DATA_W{`TDP_INIT_BIT}}};

  // Port A written last so it wins a same-address clash
  always_ff @(posedge ref_clk) begin
    if (we_b) begin
      store[addr_b] <= wdata_b;
    end
    if (we_a) begin
      store[addr_a] <= (store[addr_a] & ~bits_a) | (wdata_a & bits_a);
    end
  end

  // Read before write: a read beside a write returns the old word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_a <= {DATA_W{`TDP_Q_RST_BIT}};
    end else if (re_a) begin
      rdata_a <= store[addr_a];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_b <= {DATA_W{`TDP_Q_RST_BIT}};
    end else if (re_b) begin
      rdata_b <= store[addr_b];
    end
  end

endmodule

/* design/tdp_true_dual_port_ram.sv */
// Two-port synchronous memory with mode-dependent ports
`timescale 1ns/1ps

`include "tdp_regs.svh"

// Function
// RL1: Port A address input is always present and used.
// RL2: Port A write data and enable used in one-port and both two-port modes.
// RL3: Port B write data used only in true two-port mode.
// RL4: Port B address used in simple and true two-port modes.
// RL5: Port B write enable gates writes at port B address, true two-port only.
// RL6: Single-clock scheme times every registered port from one clock.
// RL7: Write/read scheme: write side on write clock, read side on read clock. Here both sides run on ref_clk.
// RL8: Input/output scheme: inputs on input clock, read data on output clock. Here both run on ref_clk.
// RL9: Independent scheme: all port A registers on the port A clock. Here they run on ref_clk.
// RL10: Independent scheme: all port B registers on their own port B clock. Here they share ref_clk with port A.
// RL11: Optional port A read enable qualifies reads at port A address.
// RL12: Optional port B read enable qualifies reads at port B address.
// RL13: Port A mask blocks masked byte, nibble or bit lanes from writing.
// RL14: Port A mask unavailable when built in logic cells or read-only.
// RL15: Port A address hold keeps the previously captured port A address.
// RL16: Port B address hold keeps the previously captured port B address.
// RL17: Port A read data in one-port, true two-port, read-only; data width.
// RL18: Port B read data in simple and true two-port modes; data width.
// RL19: Write stores unmasked data at captured address when enable is high.
module tdp_true_dual_port_ram
  import tdp_pkg::*;
#(
  parameter tdp_mode_t MODE = TRUE_TWO_PORT_CONFIG,
  parameter tdp_clk_scheme_t CLK_SCHEME = SINGLE_CLOCK,
  parameter int DATA_W = `TDP_DEF_DATA_W,
  parameter int ADDR_W = `TDP_DEF_ADDR_W,
  parameter int MASK_W = `TDP_DEF_MASK_W,
  parameter bit IN_LOGIC = 1'b0,
  parameter bit USE_RDEN_A = 1'b0,
  parameter bit USE_RDEN_B = 1'b0,
  parameter bit USE_MASK_A = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [DATA_W-1:0] wr_data_a,
  input wire logic wr_en_a,
  input wire logic rd_en_a,
  input wire logic [MASK_W-1:0] byte_mask_a,
  input wire logic addr_hold_a,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [DATA_W-1:0] wr_data_b,
  input wire logic wr_en_b,
  input wire logic rd_en_b,
  input wire logic addr_hold_b,
  output logic [DATA_W-1:0] rd_data_a,
  output logic rd_valid_a,
  output logic [DATA_W-1:0] rd_data_b,
  output logic rd_valid_b,
  output logic write_clash
);

  // Lanes each mask bit covers: byte, nibble or single bit
  localparam int LANE_W = DATA_W / MASK_W;

  // Which ports the chosen mode offers
  localparam bit A_WRITES = (MODE != READ_ONLY_CONFIG);
  localparam bit A_READS = (MODE != SIMPLE_TWO_PORT_CONFIG);
  localparam bit B_ADDRESSED = (MODE == SIMPLE_TWO_PORT_CONFIG) ||
                               (MODE == TRUE_TWO_PORT_CONFIG);
  localparam bit B_WRITES = (MODE == TRUE_TWO_PORT_CONFIG);
  localparam bit B_READS = B_ADDRESSED;
  localparam bit MASK_OK = USE_MASK_A && !IN_LOGIC && A_WRITES;

  // One clock carries every scheme here; the scheme only documents intent
  localparam bit ONE_CLOCK = (CLK_SCHEME == SINGLE_CLOCK) ||
                             (CLK_SCHEME == WRITE_READ_CLOCK) ||
                             (CLK_SCHEME == INPUT_OUTPUT_CLOCK) ||
                             (CLK_SCHEME == INDEPENDENT_CLOCK);

  // Gated view of the pins for the chosen mode
  logic next_we_a;
  logic next_re_a;
  logic [DATA_W-1:0] next_wdata_a;
  logic [ADDR_W-1:0] next_addr_b;
  logic next_hold_b;
  logic next_we_b;
  logic next_re_b;
  logic [DATA_W-1:0] next_wdata_b;
  logic [MASK_W-1:0] next_mask_a;
  logic [DATA_W-1:0] mask_bits;

  // Captured inputs
  logic [ADDR_W-1:0] cap_addr_a;
  logic [ADDR_W-1:0] cap_addr_b;
  logic [DATA_W-1:0] cap_wdata_a;
  logic [DATA_W-1:0] cap_wdata_b;
  logic [MASK_W-1:0] cap_mask_a;
  logic cap_we_a;
  logic cap_we_b;
  logic cap_re_a;
  logic cap_re_b;

  // Array read data and its tracking strobes
  logic [DATA_W-1:0] mem_rdata_a;
  logic [DATA_W-1:0] mem_rdata_b;
  logic pend_a;
  logic pend_b;

  always_comb begin
    next_we_a = A_WRITES && ONE_CLOCK && wr_en_a; // RL2
    next_wdata_a = A_WRITES ? wr_data_a : {DATA_W{`TDP_DATA_RST_BIT}}; // RL2
    next_re_a = A_READS && (USE_RDEN_A ? rd_en_a : 1'b1); // RL11
  end

  always_comb begin
    next_addr_b = B_ADDRESSED ? addr_b : {ADDR_W{`TDP_ADDR_RST_BIT}}; // RL4
    next_hold_b = B_ADDRESSED && addr_hold_b; // RL4
    next_we_b = B_WRITES && wr_en_b; // RL5
    next_wdata_b = B_WRITES ? wr_data_b : {DATA_W{`TDP_DATA_RST_BIT}}; // RL3
    next_re_b = B_READS && (USE_RDEN_B ? rd_en_b : 1'b1); // RL12
  end

  // No mask in logic cells or read-only: every lane writes
  always_comb begin
    next_mask_a = MASK_OK ? byte_mask_a : {MASK_W{`TDP_MASK_RST_BIT}}; // RL14
  end

  // Address capture; hold freezes the previous address
  tdp_addr_reg #(
    .ADDR_W(ADDR_W)
  ) u_addr_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .addr_in(addr_a),
    .hold(addr_hold_a),
    .addr_q(cap_addr_a)
  ); // RL1 RL15

  tdp_addr_reg #(
    .ADDR_W(ADDR_W)
  ) u_addr_b (
    .ref_clk(ref_clk),
    .reset(reset),
    .addr_in(next_addr_b),
    .hold(next_hold_b),
    .addr_q(cap_addr_b)
  ); // RL16

  // Port A write side inputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_we_a <= `TDP_EN_RST;
      cap_wdata_a <= {DATA_W{`TDP_DATA_RST_BIT}};
      cap_mask_a <= {MASK_W{`TDP_MASK_RST_BIT}};
    end else begin
      cap_we_a <= next_we_a; // RL6 RL7 RL8 RL9
      cap_wdata_a <= next_wdata_a;
      cap_mask_a <= next_mask_a;
    end
  end

  // Port A read side inputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_re_a <= `TDP_EN_RST;
    end else begin
      cap_re_a <= next_re_a; // RL7 RL9
    end
  end

  // Port B inputs kept apart from port A logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_we_b <= `TDP_EN_RST;
      cap_re_b <= `TDP_EN_RST;
      cap_wdata_b <= {DATA_W{`TDP_DATA_RST_BIT}};
    end else begin
      cap_we_b <= next_we_b; // RL10
      cap_re_b <= next_re_b; // RL10
      cap_wdata_b <= next_wdata_b;
    end
  end

  // Each mask bit widens to its lane of data bits
  genvar lane;
  generate
    for (lane = 0; lane < MASK_W; lane++) begin : g_lane
      assign mask_bits[lane*LANE_W +: LANE_W] = {LANE_W{cap_mask_a[lane]}}; // RL13
    end
  endgenerate

  tdp_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_mem (
    .ref_clk(ref_clk),
    .reset(reset),
    .we_a(cap_we_a),
    .addr_a(cap_addr_a),
    .wdata_a(cap_wdata_a),
    .bits_a(mask_bits),
    .re_a(cap_re_a),
    .we_b(cap_we_b),
    .addr_b(cap_addr_b),
    .wdata_b(cap_wdata_b),
    .re_b(cap_re_b),
    .rdata_a(mem_rdata_a),
    .rdata_b(mem_rdata_b)
  ); // RL13 RL19

  // Strobes follow each read through the array stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_a <= `TDP_EN_RST;
      pend_b <= `TDP_EN_RST;
    end else begin
      pend_a <= cap_re_a; // RL11
      pend_b <= cap_re_b; // RL12
    end
  end

  // Output registers; a skipped read leaves the last word in place
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data_a <= {DATA_W{`TDP_Q_RST_BIT}};
      rd_valid_a <= `TDP_EN_RST;
    end else begin
      rd_valid_a <= A_READS && pend_a; // RL17
      if (A_READS && pend_a) begin
        rd_data_a <= mem_rdata_a; // RL8 RL17
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data_b <= {DATA_W{`TDP_Q_RST_BIT}};
      rd_valid_b <= `TDP_EN_RST;
    end else begin
      rd_valid_b <= B_READS && pend_b; // RL18
      if (B_READS && pend_b) begin
        rd_data_b <= mem_rdata_b; // RL10 RL18
      end
    end
  end

  // Same-address double write: port A wins, flagged for the user
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      write_clash <= `TDP_EN_RST;
    end else begin
      write_clash <= cap_we_a && cap_we_b && (cap_addr_a == cap_addr_b);
    end
  end

endmodule

/* test/tdp_true_dual_port_ram_assertions.sv */
// Port-level checks for the two-port memory
`timescale 1ns/1ps
module tdp_true_dual_port_ram_checker #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic wr_en_a,
  input wire logic rd_en_a,
  input wire logic addr_hold_a,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic wr_en_b,
  input wire logic rd_en_b,
  input wire logic addr_hold_b,
  input wire logic [DATA_W-1:0] rd_data_a,
  input wire logic rd_valid_a,
  input wire logic [DATA_W-1:0] rd_data_b,
  input wire logic rd_valid_b,
  input wire logic write_clash
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rd_a; rd_en_a |-> ##3 rd_valid_a; endproperty
  a_rd_a: assert property (p_rd_a) else $error("read A gave no valid");
  property p_nord_a; !rd_en_a |-> ##3 !rd_valid_a; endproperty
  a_nord_a: assert property (p_nord_a) else $error("valid A without read");
  property p_rd_b; rd_en_b |-> ##3 rd_valid_b; endproperty
  a_rd_b: assert property (p_rd_b) else $error("read B gave no valid");
  property p_nord_b; !rd_en_b |-> ##3 !rd_valid_b; endproperty
  a_nord_b: assert property (p_nord_b) else $error("valid B without read");
  // Reset clears the output, so skip the edge just after it
  property p_dat_a; ($changed(rd_data_a) && !$past(reset)) |-> rd_valid_a; endproperty
  a_dat_a: assert property (p_dat_a) else $error("read data A moved alone");
  property p_dat_b; ($changed(rd_data_b) && !$past(reset)) |-> rd_valid_b; endproperty
  a_dat_b: assert property (p_dat_b) else $error("read data B moved alone");
  property p_clash;
    (wr_en_a && wr_en_b && !addr_hold_a && !addr_hold_b && addr_a == addr_b) |-> ##2 write_clash;
  endproperty
  a_clash: assert property (p_clash) else $error("same-address writes not flagged");
  property p_clash_src; write_clash |-> $past(wr_en_a, 2) && $past(wr_en_b, 2); endproperty
  a_clash_src: assert property (p_clash_src) else $error("clash flag without writes");
endmodule

bind tdp_true_dual_port_ram tdp_true_dual_port_ram_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
  i_tdp_true_dual_port_ram_checker (.ref_clk, .reset, .addr_a, .wr_en_a, .rd_en_a,
  .addr_hold_a, .addr_b, .wr_en_b, .rd_en_b, .addr_hold_b, .rd_data_a, .rd_valid_a,
  .rd_data_b, .rd_valid_b, .write_clash);

/* test/tdp_user_model.sv */
// User logic model driving both memory ports
`timescale 1ns/1ps
module tdp_user_model #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8,
  parameter int MASK_W = 1
) (
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] addr_a,
  output logic [DATA_W-1:0] wr_data_a,
  output logic wr_en_a,
  output logic rd_en_a,
  output logic [MASK_W-1:0] byte_mask_a,
  output logic addr_hold_a,
  output logic [ADDR_W-1:0] addr_b,
  output logic [DATA_W-1:0] wr_data_b,
  output logic wr_en_b,
  output logic rd_en_b,
  output logic addr_hold_b
);
  initial begin
    {addr_a, wr_data_a, wr_en_a, rd_en_a, byte_mask_a, addr_hold_a} = '0;
    {addr_b, wr_data_b, wr_en_b, rd_en_b, addr_hold_b} = '0;
  end
  // One request per edge from the single source clock
  task automatic op(input logic [ADDR_W-1:0] aa, input logic [DATA_W-1:0] da, input logic wa,
    input logic ra, input logic [MASK_W-1:0] ma, input logic ha, input logic [ADDR_W-1:0] ab,
    input logic [DATA_W-1:0] db, input logic wb, input logic rb, input logic hb);
    @(posedge ref_clk);
    addr_a <= aa;
    wr_data_a <= da;
    wr_en_a <= wa;
    rd_en_a <= ra;
    byte_mask_a <= ma;
    addr_hold_a <= ha;
    addr_b <= ab;
    wr_data_b <= db;
    wr_en_b <= wb;
    rd_en_b <= rb;
    addr_hold_b <= hb;
  endtask
endmodule

/* test/tdp_true_dual_port_ram_tb_top.sv */
// Self-checking bench for the two-port memory
`timescale 1ns/1ps
module tdp_true_dual_port_ram_tb_top;
  import tdp_pkg::*;
  localparam int DW = 8;
  localparam int AW = 8;
  localparam int MW = 2;
  logic ref_clk, reset, wr_en_a, rd_en_a, addr_hold_a, wr_en_b, rd_en_b, addr_hold_b;
  logic rd_valid_a, rd_valid_b, write_clash;
  logic [AW-1:0] addr_a, addr_b;
  logic [DW-1:0] wr_data_a, wr_data_b, rd_data_a, rd_data_b;
  logic [MW-1:0] byte_mask_a;
  int n_mismatch = 0;
  int num_checks = 0;
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  tdp_true_dual_port_ram #(.MODE(TRUE_TWO_PORT_CONFIG), .MASK_W(MW), .USE_RDEN_A(1'b1),
    .USE_RDEN_B(1'b1), .USE_MASK_A(1'b1)) i_tdp_true_dual_port_ram (.ref_clk, .reset,
    .addr_a, .wr_data_a, .wr_en_a, .rd_en_a, .byte_mask_a, .addr_hold_a, .addr_b, .wr_data_b,
    .wr_en_b, .rd_en_b, .addr_hold_b, .rd_data_a, .rd_valid_a, .rd_data_b, .rd_valid_b,
    .write_clash);
  tdp_user_model #(.MASK_W(MW)) i_tdp_user_model (.ref_clk, .addr_a, .wr_data_a, .wr_en_a,
    .rd_en_a, .byte_mask_a, .addr_hold_a, .addr_b, .wr_data_b, .wr_en_b, .rd_en_b,
    .addr_hold_b);
  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) i_tdp_user_model.op('0, '0, 1'h0, 1'h0, '0, 1'h0, '0, '0, 1'h0, 1'h0, 1'h0);
  endtask
  task automatic rdx(input logic [AW-1:0] a, input logic [AW-1:0] b, input logic ra,
    input logic rb);
    i_tdp_user_model.op(a, '0, 1'h0, ra, '0, 1'h0, b, '0, 1'h0, rb, 1'h0);
  endtask
  // Fixed three-edge read latency, both ports at once
  task automatic rd(input logic [AW-1:0] a, input logic [AW-1:0] b, input logic [DW-1:0] ea,
    input logic [DW-1:0] eb);
    rdx(a, b, 1'h1, 1'h1);
    idle(3);
    #1;
    chk("rd_valid_a", 8'h1, DW'(rd_valid_a));
    chk("rd_data_a", ea, rd_data_a);
    chk("rd_valid_b", 8'h1, DW'(rd_valid_b));
    chk("rd_data_b", eb, rd_data_b);
  endtask
  // Watchdog: no scenario should come near this
  initial begin
    #1ms;
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset = 1'h1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    i_tdp_user_model.op(8'h05, 8'h3c, 1'h1, 1'h0, 2'h3, 1'h0, '0, '0, 1'h0, 1'h0, 1'h0);
    rd(8'h05, 8'h05, 8'h3c, 8'h3c);
    i_tdp_user_model.op('0, '0, 1'h0, 1'h0, '0, 1'h0, 8'h07, 8'ha5, 1'h1, 1'h0, 1'h0);
    rd(8'h07, 8'h07, 8'ha5, 8'ha5);
    i_tdp_user_model.op('0, '0, 1'h0, 1'h0, '0, 1'h0, 8'h07, 8'hff, 1'h0, 1'h0, 1'h0);
    rd(8'h07, 8'h07, 8'ha5, 8'ha5);
    i_tdp_user_model.op(8'h05, 8'hff, 1'h1, 1'h0, 2'h1, 1'h0, '0, '0, 1'h0, 1'h0, 1'h0);
    rd(8'h05, 8'h05, 8'h3f, 8'h3f);
    rdx(8'h07, 8'h07, 1'h0, 1'h0);
    idle(3);
    #1;
    chk("rd_valid_a", 8'h0, DW'(rd_valid_a));
    chk("rd_valid_b", 8'h0, DW'(rd_valid_b));
    chk("rd_data_a", 8'h3f, rd_data_a);
    rdx(8'h09, 8'h0b, 1'h0, 1'h0);
    i_tdp_user_model.op(8'h05, 8'h11, 1'h1, 1'h0, 2'h3, 1'h1, 8'h05, 8'h22, 1'h1, 1'h0,
      1'h1);
    rd(8'h09, 8'h0b, 8'h11, 8'h22);
    i_tdp_user_model.op(8'h14, 8'h01, 1'h1, 1'h0, 2'h3, 1'h0, 8'h14, 8'h02, 1'h1, 1'h0,
      1'h0);
    idle(2);
    #1;
    chk("write_clash", 8'h1, DW'(write_clash));
    // Upper lane only: clears the high nibble of 3f
    i_tdp_user_model.op(8'h05, 8'h00, 1'h1, 1'h0, 2'h2, 1'h0, '0, '0, 1'h0, 1'h0, 1'h0);
    rd(8'h14, 8'h14, 8'h01, 8'h01);
    // Mid-run reset clears outputs but keeps stored words
    @(posedge ref_clk);
    reset <= 1'h1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    chk("rd_data_a", 8'h0, rd_data_a);
    rd(8'h14, 8'h05, 8'h01, 8'h0f);
    finish_test();
  end
endmodule
